// *** hw/scfh_handler.v ***
// Serial command frame handler: UART receive/transmit, frame check,
// information and setup-mode commands.
// Assumes a half-duplex transceiver driven by tx_enable, rxd from a pin.
// Behaviour
// R1: Half-duplex; answer only after command fully received.
// R2: 9600 baud, 8 data, 1 stop, no parity.
// R3: Frame: start, address, body, end, checksum.
// R4: Start byte 0x02, end byte 0x03.
// R5: Address byte is address plus 0x80.
// R6: Own address 1..32; answer only own address.
// R7: Host keeps addresses distinct on the bus.
// R8: Checksum is byte sum mod 256 incl. delimiters.
// R9: Parameter commands reply result char '0'/'1'.
// R10: 0x10 S/F/N returns serial, firmware, name.
// R11: Setup mode read 0x10 M, write 0x11 M.
// R12: Mode '0' panel start, '4' external start.
// R13: In remote mode write changes start source only.
// R14: Bad address or checksum frames get no reply.
`timescale 1ns/1ns
`include "scfh_consts.vh"

module scfh_handler
#(
   parameter [31:0] BIT_CYCLES = `SCFH_BIT_CYCLES // Clock cycles per bit
)
(
   // Clock and reset
   input  wire         clk,
   input  wire         reset,
   // Serial link
   input  wire         rxd,
   output reg          txd,
   output reg          tx_enable,
   // Configuration
   input  wire [5:0]   station_address,
   input  wire         remote_mode,
   input  wire [63:0]  serial_number,
   input  wire [63:0]  firmware_version,
   input  wire [63:0]  device_name,
   // Setup state
   output reg  [7:0]   setup_mode,
   output reg          start_external
);

   localparam [13:0] BIT_CYC  = BIT_CYCLES[13:0];
   localparam [13:0] HALF_CYC = BIT_CYC >> 1;

   // Frame states, one-hot
   localparam [5:0] S_IDLE = 6'b000001;
   localparam [5:0] S_ADDR = 6'b000010;
   localparam [5:0] S_BODY = 6'b000100;
   localparam [5:0] S_SUM  = 6'b001000;
   localparam [5:0] S_EXEC = 6'b010000;
   localparam [5:0] S_SEND = 6'b100000;

   // Byte at index i of a packed 8-byte string, first byte in the top
   function [7:0] pick;
      input [63:0] str;
      input [3:0]  i;
      begin
         pick = str[(7 - i[2:0]) * 8 +: 8];
      end
   endfunction

   // Input synchroniser
   reg        rx_s1;
   reg        rx_s2;
   always @(posedge clk)
   begin
      if (reset)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end
      else
      begin
         rx_s1 <= rxd;
         rx_s2 <= rx_s1;
      end
   end

   // UART receiver, sampling each bit in its middle [R2]
   reg [13:0] rx_cnt;
   reg [3:0]  rx_bit;
   reg        rx_busy;
   reg [7:0]  rx_shift;
   reg        rx_valid;
   reg [7:0]  rx_byte;
   always @(posedge clk)
   begin
      rx_valid <= 1'b0;
      if (reset)
      begin
         rx_cnt   <= 14'h0000;
         rx_bit   <= 4'h0;
         rx_busy  <= 1'b0;
         rx_shift <= 8'h00;
         rx_byte  <= 8'h00;
      end
      else if (!rx_busy)
      begin
         if (!rx_s2 && !tx_enable)
         begin
            rx_busy <= 1'b1;
            rx_cnt  <= HALF_CYC;
            rx_bit  <= 4'h0;
         end
      end
      else if (rx_cnt != 14'h0000)
         rx_cnt <= rx_cnt - 14'h0001;
      else
      begin
         rx_cnt <= BIT_CYC - 14'h0001;
         rx_bit <= rx_bit + 4'h1;
         if (rx_bit == 4'h0)
         begin
            // False start bit: glitch shorter than half a bit
            if (rx_s2)
               rx_busy <= 1'b0;
         end
         else if (rx_bit <= `SCFH_DATA_BITS)
            rx_shift <= {rx_s2, rx_shift[7:1]};
         else
         begin
            rx_busy <= 1'b0;
            // Framing error (low stop bit) drops the byte
            if (rx_s2)
            begin
               rx_valid <= 1'b1;
               rx_byte  <= rx_shift;
            end
         end
      end
   end

   // Frame parser and reply sequencer
   reg [5:0]  state;
   reg [7:0]  sum;
   reg [7:0]  body [0:15];
   reg [4:0]  body_len;
   reg [7:0]  reply [0:15];
   reg [4:0]  reply_len;
   reg [4:0]  tx_idx;
   reg [7:0]  tx_sum;
   reg        tx_load;
   reg        tx_busy;
   reg [7:0]  tx_data;
   integer    k;

   wire [7:0] own_addr = `SCFH_ADDR_BIAS + {2'b00, station_address};
   wire       addr_ok  = station_address >= `SCFH_ADDR_MIN &&
                         station_address <= `SCFH_ADDR_MAX;

   always @(posedge clk)
   begin
      tx_load <= 1'b0;
      if (reset)
      begin
         state          <= S_IDLE;
         sum            <= 8'h00;
         body_len       <= 5'd0;
         reply_len      <= 5'd0;
         tx_idx         <= 5'd0;
         tx_sum         <= 8'h00;
         tx_data        <= 8'h00;
         setup_mode     <= `SCFH_MODE_RESET;
         start_external <= 1'b0;
         for (k = 0; k < 16; k = k + 1)
         begin
            body[k]  <= 8'h00;
            reply[k] <= 8'h00;
         end
      end
      else
      case (state)
         S_IDLE:
            if (rx_valid && rx_byte == `SCFH_START_BYTE)    // [R3] [R4]
            begin
               sum   <= rx_byte;
               state <= S_ADDR;
            end
         S_ADDR:
            if (rx_valid)
            begin
               sum      <= sum + rx_byte;                   // [R8]
               body_len <= 5'd0;
               // Foreign address: fall back and wait for next start
               if (addr_ok && rx_byte == own_addr)          // [R5] [R6]
                  state <= S_BODY;
               else
                  state <= S_IDLE;                          // [R14]
            end
         S_BODY:
            if (rx_valid)
            begin
               sum <= sum + rx_byte;
               if (rx_byte == `SCFH_END_BYTE)
                  state <= S_SUM;
               else if (body_len == `SCFH_MAX_BODY)
                  state <= S_IDLE;
               else
               begin
                  body[body_len[3:0]] <= rx_byte;
                  body_len            <= body_len + 5'd1;
               end
            end
         S_SUM:
            if (rx_valid)
               // Reply only after the whole command, checksum included
               state <= (rx_byte == sum) ? S_EXEC : S_IDLE; // [R1] [R8] [R14]
         S_EXEC:
         begin
            reply[0]  <= `SCFH_START_BYTE;
            reply[1]  <= own_addr;
            reply[2]  <= body[0];
            reply[3]  <= body[1];
            reply_len <= 5'd4;
            state     <= S_SEND;
            tx_idx    <= 5'd0;
            tx_sum    <= 8'h00;
            if (body_len == 5'd2 && body[0] == `SCFH_CMD_READ)
            begin
               case (body[1])                               // [R10] [R11]
                  `SCFH_LETTER_SERIAL,
                  `SCFH_LETTER_FW,
                  `SCFH_LETTER_NAME:
                  begin
                     for (k = 0; k < 8; k = k + 1)
                        reply[4 + k] <= pick(
                           body[1] == `SCFH_LETTER_SERIAL ? serial_number :
                           body[1] == `SCFH_LETTER_FW ? firmware_version :
                           device_name, k[3:0]);
                     reply_len <= 5'd4 + {1'b0, `SCFH_INFO_LEN};
                  end
                  `SCFH_LETTER_MODE:
                  begin
                     reply[4]  <= setup_mode;
                     reply_len <= 5'd5;
                  end
                  default:
                     state <= S_IDLE;
               endcase
            end
            else if (body_len == 5'd3 && body[0] == `SCFH_CMD_WRITE &&
                     body[1] == `SCFH_LETTER_MODE)
            begin
               reply_len <= 5'd5;
               if (body[2] == `SCFH_MODE_PANEL ||
                   body[2] == `SCFH_MODE_EXT)               // [R12]
               begin
                  reply[4]       <= `SCFH_RESULT_OK;        // [R9]
                  start_external <= body[2] == `SCFH_MODE_EXT;
                  // Remote: only the start source moves, setup stays
                  if (!remote_mode)                         // [R13]
                     setup_mode <= body[2];
               end
               else
                  reply[4] <= `SCFH_RESULT_FAIL;            // [R9]
            end
            else
               state <= S_IDLE;
         end
         S_SEND:
            if (!tx_busy && !tx_load)
            begin
               tx_load <= 1'b1;
               tx_idx  <= tx_idx + 5'd1;
               if (tx_idx < reply_len)
               begin
                  tx_data <= reply[tx_idx[3:0]];
                  tx_sum  <= tx_sum + reply[tx_idx[3:0]];   // [R8]
               end
               else if (tx_idx == reply_len)
               begin
                  tx_data <= `SCFH_END_BYTE;                // [R3]
                  tx_sum  <= tx_sum + `SCFH_END_BYTE;
               end
               else if (tx_idx == reply_len + 5'd1)
                  tx_data <= tx_sum;                        // [R8]
               else
               begin
                  tx_load <= 1'b0;
                  state   <= S_IDLE;
               end
            end
         default:
            state <= S_IDLE;
      endcase
   end

   // UART transmitter; drives the bus only while a reply is out [R1] [R2]
   reg [13:0] tx_cnt;
   reg [3:0]  tx_bit;
   reg [9:0]  tx_shift;
   always @(posedge clk)
   begin
      if (reset)
      begin
         tx_cnt    <= 14'h0000;
         tx_bit    <= 4'h0;
         tx_shift  <= 10'h3FF;
         tx_busy   <= 1'b0;
         txd       <= 1'b1;
         tx_enable <= 1'b0;
      end
      else if (tx_load)
      begin
         tx_shift  <= {1'b1, tx_data, 1'b0};
         tx_busy   <= 1'b1;
         tx_bit    <= 4'h0;
         tx_cnt    <= 14'h0000;
         tx_enable <= 1'b1;
      end
      else if (tx_busy)
      begin
         if (tx_cnt != 14'h0000)
            tx_cnt <= tx_cnt - 14'h0001;
         else if (tx_bit == 4'd10)
         begin
            tx_busy <= 1'b0;
            txd     <= 1'b1;
            // Release the driver once the final byte has gone
            if (state != S_SEND)
               tx_enable <= 1'b0;
         end
         else
         begin
            txd      <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit   <= tx_bit + 4'h1;
            tx_cnt   <= BIT_CYC - 14'h0001;
         end
      end
      else if (state != S_SEND)
         tx_enable <= 1'b0;
   end

endmodule

// *** include/scfh_consts.vh ***
// Constants for the serial command frame handler.
// Included by the handler; defines only, no logic.
`ifndef SCFH_CONSTS_VH
`define SCFH_CONSTS_VH

`define SCFH_CLK_HZ        125000000
`define SCFH_BAUD          9600
`define SCFH_BIT_CYCLES    (`SCFH_CLK_HZ / `SCFH_BAUD)
// Short bit period for simulation; keeps a bench run brief
`define SCFH_FAST_BIT_CYCLES 32'h0000_0018
`define SCFH_DATA_BITS     8
`define SCFH_STOP_BITS     1
`define SCFH_START_BYTE    8'h02
`define SCFH_END_BYTE      8'h03
`define SCFH_ADDR_BIAS     8'h80
`define SCFH_ADDR_MIN      6'd1
`define SCFH_ADDR_MAX      6'd32
`define SCFH_CMD_READ      8'h10
`define SCFH_CMD_WRITE     8'h11
`define SCFH_LETTER_SERIAL 8'h53
`define SCFH_LETTER_FW     8'h46
`define SCFH_LETTER_NAME   8'h4E
`define SCFH_LETTER_MODE   8'h4D
`define SCFH_RESULT_OK     8'h30
`define SCFH_RESULT_FAIL   8'h31
`define SCFH_MODE_PANEL    8'h30
`define SCFH_MODE_EXT      8'h34
`define SCFH_MODE_RESET    8'h30
`define SCFH_MAX_BODY      5'd16
`define SCFH_INFO_LEN      4'd8

`endif

// *** tb/scfh_props.sv ***
// Port assertions for the serial command frame handler.
// Bound to scfh_handler; one clock, synchronous reset.
`timescale 1ns/1ns
module scfh_props
#(
   parameter int BIT_CYCLES = 13020
)
(
   // Clock and reset
   input wire       clk,
   input wire       reset,
   // Watched ports
   input wire       rxd,
   input wire       txd,
   input wire       tx_enable,
   input wire       remote_mode,
   input wire [7:0] setup_mode
);
   localparam int MIN_RUN = BIT_CYCLES - 1;
   reg [15:0] run;
   reg        prev;
   // Cycles since txd last moved, to police the bit period
   always @(posedge clk)
   begin
      prev <= txd;
      if (reset || txd != prev)
         run <= 16'h0000;
      else if (run != 16'hFFFF)
         run <= run + 16'h0001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // The driver turns on one cycle before the start bit goes out
   sequence s_start;
      txd ##1 !txd [*8];
   endsequence
   idle_high_a: assert property (!tx_enable |-> txd)
      else $error("txd low while driver off");
   start_bit_a: assert property ($rose(tx_enable) |-> s_start)
      else $error("reply does not open with a start bit");
   stop_end_a: assert property ($fell(tx_enable) |-> $past(txd))
      else $error("driver released before stop bit");
   bit_time_a: assert property (tx_enable && $changed(txd) |->
      run >= MIN_RUN)
      else $error("txd bit shorter than one bit period");
   half_duplex_a: assert property ($rose(tx_enable) |-> rxd)
      else $error("reply started while host sends");
   mode_legal_a: assert property (setup_mode == 8'h30 ||
      setup_mode == 8'h34)
      else $error("setup mode outside legal set");
   remote_keep_a: assert property ($changed(setup_mode) |->
      !remote_mode)
      else $error("setup mode changed in remote mode");
   reset_vals_a: assert property (disable iff (1'b0)
      reset |=> setup_mode == 8'h30 && txd && !tx_enable)
      else $error("bad values after reset");
endmodule

bind scfh_handler scfh_props #(.BIT_CYCLES(BIT_CYCLES)) i_scfh_props (
   .clk(clk), .reset(reset),
   .rxd(rxd), .txd(txd), .tx_enable(tx_enable),
   .remote_mode(remote_mode), .setup_mode(setup_mode));

// *** tb/scfh_host.sv ***
// Bus host model: 8N1 characters and whole frames on the link.
// Driven by bench tasks; bit period fixed by the constants header.
`timescale 1ns/1ns
`include "scfh_consts.vh"
module scfh_host
(
   // Clock
   input wire clk,
   // Serial link
   input wire txd,
   output reg rxd
);
   localparam integer BIT = `SCFH_FAST_BIT_CYCLES;
   initial rxd = 1'b1;
   // Stop bit is split across calls so a reply is never missed
   task put_byte(input [7:0] b);
      integer i;
      repeat (BIT - BIT / 4) @(negedge clk);
      for (i = 0; i < 10; i = i + 1)
      begin
         @(negedge clk);
         rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
         repeat (((i == 9) ? BIT / 4 : BIT) - 1) @(negedge clk);
      end
   endtask
   task get_byte(output [7:0] b, output ok);
      integer n;
      b = 8'h00;
      ok = 1'b0;
      for (n = 0; n < 3 * BIT && txd; n = n + 1)
         @(negedge clk);
      if (!txd)
      begin
         ok = 1'b1;
         repeat (BIT + BIT / 2) @(negedge clk);
         for (n = 0; n < 8; n = n + 1)
         begin
            b[n] = txd;
            repeat (BIT) @(negedge clk);
         end
      end
   endtask
   // Only called once any reply is over; one device on the bus
   task send_frame(input [7:0] adr, input [7:0] c, input [7:0] l,
                   input [7:0] p, input integer np, input [7:0] skew);
      reg [7:0] s;
      s = 8'h02 + 8'h80 + adr + c + l + 8'h03 + skew;
      if (np)
         s = s + p;
      put_byte(8'h02);
      put_byte(8'h80 + adr);
      put_byte(c);
      put_byte(l);
      if (np)
         put_byte(p);
      put_byte(8'h03);
      put_byte(s);
   endtask
endmodule

// *** tb/scfh_handler_tb.sv ***
// Bench for the frame handler: host model, reference model, checks.
// Runs the handler with a short bit period to keep the run brief.
`timescale 1ns/1ns
`include "scfh_consts.vh"
module scfh_handler_tb;
   reg         clk;
   reg         reset;
   wire        rxd;
   wire        txd;
   wire        tx_enable;
   reg  [5:0]  station_address;
   reg         remote_mode;
   reg  [63:0] serial_number;
   reg  [63:0] firmware_version;
   reg  [63:0] device_name;
   wire [7:0]  setup_mode;
   wire        start_external;
   wire [7:0]  adr = {2'b00, station_address};
   integer     errors;
   integer     n_tests;
   integer     mode;
   integer     ext;
   integer     k;
   integer     j;
   reg  [15:0] lfsr;
   reg  [63:0] info;
   reg  [23:0] lt;
   reg  [7:0]  q[$];

   scfh_handler #(.BIT_CYCLES(`SCFH_FAST_BIT_CYCLES)) i_scfh_handler (
      .clk(clk), .reset(reset), .rxd(rxd),
      .txd(txd), .tx_enable(tx_enable),
      .station_address(station_address), .remote_mode(remote_mode),
      .serial_number(serial_number), .firmware_version(firmware_version),
      .device_name(device_name), .setup_mode(setup_mode),
      .start_external(start_external));
   scfh_host i_scfh_host (.clk(clk), .txd(txd), .rxd(rxd));

   always #4 clk = ~clk;

   function [15:0] lfsr_next(input [15:0] v);
      lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task rnd(output [63:0] v);
      integer i;
      for (i = 0; i < 4; i = i + 1)
      begin
         lfsr = lfsr_next(lfsr);
         v = {v[47:0], lfsr};
      end
   endtask
   task check(input [7:0] got, input [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Frames the expected body in q and compares the whole reply
   task expect_reply;
      reg [7:0] b;
      reg       ok;
      reg [7:0] s;
      integer   i;
      q.push_front(8'h80 + adr);
      q.push_front(8'h02);
      q.push_back(8'h03);
      s = 8'h00;
      for (i = 0; i < q.size(); i = i + 1)
         s = s + q[i];
      q.push_back(s);
      for (i = 0; i < q.size(); i = i + 1)
      begin
         i_scfh_host.get_byte(b, ok);
         check({7'h00, ok}, 8'h01);
         check(b, q[i]);
      end
      // Next frame only once the driver is off
      while (tx_enable)
         @(negedge clk);
      q.delete();
   endtask
   task rd_mode;
      i_scfh_host.send_frame(adr, 8'h10, 8'h4D, 8'h00, 0, 8'h00);
      q.push_back(8'h10);
      q.push_back(8'h4D);
      q.push_back(mode[7:0]);
      expect_reply;
   endtask
   task wr_mode(input [7:0] m);
      reg good;
      good = (m == 8'h30 || m == 8'h34);
      i_scfh_host.send_frame(adr, 8'h11, 8'h4D, m, 1, 8'h00);
      q.push_back(8'h11);
      q.push_back(8'h4D);
      q.push_back(good ? 8'h30 : 8'h31);
      if (good)
      begin
         ext = (m == 8'h34);
         if (!remote_mode)
            mode = m;
      end
      expect_reply;
      check(setup_mode, mode[7:0]);
      check({7'h00, start_external}, ext[7:0]);
   endtask
   task silent(input [7:0] a, input [7:0] skew);
      reg [7:0] b;
      reg       ok;
      i_scfh_host.send_frame(a, 8'h10, 8'h4D, 8'h00, 0, skew);
      i_scfh_host.get_byte(b, ok);
      check({7'h00, ok}, 8'h00);
   endtask
   task complete_run;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // About twice the expected run length
   initial
   begin
      #(32'h000A_FC80);
      errors = errors + 1;
      complete_run;
   end

   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      remote_mode = 1'b0;
      errors = 0;
      n_tests = 0;
      mode = 8'h30;
      ext = 0;
      lt = "SFN";
      lfsr = 16'hAA99;
      rnd(serial_number);
      rnd(firmware_version);
      rnd(device_name);
      station_address = {1'b0, lfsr[4:0]} + 6'd1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      check(setup_mode, 8'h30);
      check({7'h00, start_external}, 8'h00);
      for (k = 0; k < 3; k = k + 1)
      begin
         rnd(serial_number);
         rnd(firmware_version);
         rnd(device_name);
         i_scfh_host.send_frame(adr, 8'h10, lt[23 - 8 * k -: 8], 8'h00,
                                0, 8'h00);
         info = (k == 0) ? serial_number :
                (k == 1) ? firmware_version : device_name;
         q.push_back(8'h10);
         q.push_back(lt[23 - 8 * k -: 8]);
         for (j = 0; j < 8; j = j + 1)
            q.push_back(info[63 - 8 * j -: 8]);
         expect_reply;
      end
      rd_mode;
      wr_mode(8'h34);
      wr_mode(8'h32);
      silent(adr, 8'h01);
      silent({2'b00, station_address ^ 6'h01}, 8'h00);
      // Address zero is outside the legal range and never answers
      station_address = 6'd0;
      silent(8'h00, 8'h00);
      lfsr = lfsr_next(lfsr);
      station_address = {1'b0, lfsr[4:0]} + 6'd1;
      @(negedge clk);
      rd_mode;
      remote_mode = 1'b1;
      wr_mode(8'h30);
      rd_mode;
      wr_mode(8'h34);
      remote_mode = 1'b0;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      mode = 8'h30;
      ext = 0;
      check(setup_mode, 8'h30);
      check({7'h00, start_external}, 8'h00);
      rd_mode;
      complete_run;
   end
endmodule
